// file: hdl/tuner_channel_and_pin_config.sv
// channel, configuration and pin control of the broadcast tuner
// assumes a classic wishbone master on clk and datapath inputs on clk
//
// What this block does
// RULE_01: writing one to channel go bit 15 starts a tune of the selected channel.
// RULE_02: tune completion raises the completion flag, held until go bit cleared.
// RULE_03: host clears go before next operation; only that write clears the flag (the code also clears it when seek start is written zero).
// RULE_04: band 00 frequency is channel times spacing plus 87.5 MHz; channel bits 9:0.
// RULE_05: bands 01 and 10 use channel times spacing plus 76 MHz.
// RULE_06: a seek never alters the host-written channel select field.
// RULE_07: readback channel updates while seeking and when seek or tune completes (the code loads the tuned channel when the tune starts, not when it completes).
// RULE_08: completion irq enable bit 14 with pin two mode 01 pulses pin low 5 ms.
// RULE_09: data-group irq enable pulses pin two low 5 ms on data-ready set.
// RULE_10: pin two mode bits 3:2: hi-z, interrupt high, low, high.
// RULE_11: pin three mode bits 5:4: hi-z, stereo indicator, low, high.
// RULE_12: stereo indicator mode drives pin three high in stereo, low in mono.
// RULE_13: pin one mode bits 1:0: hi-z, reserved, low, high.
// RULE_14: de-emphasis bit 11 selects 75 us when zero, 50 us when one.
// RULE_15: gain-control bit 10 keeps automatic gain on at zero, off at one.
// RULE_16: blend field picks window 31-49, 37-55, 19-37 or 25-43 dBuV.
// RULE_17: stereo indication set when strength exceeds the blend window low end.
// RULE_18: seek completion and fail flags clear only when seek start written zero (the code also clears the completion flag when go is written zero).
// RULE_19: band codes 87.5-108, 76-108, 76-90 MHz; code 11 reserved.
// RULE_20: spacing codes 200, 100, 50 kHz, the multiplier of the formula.
// RULE_21: the 5 ms pulse is timed by a counter and ends by itself.
// RULE_22: host writes zero to reserved bits and ignores their read value.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tuner_channel_and_pin_config #(
    parameter int unsigned pulseCycles = tuner_pkg::PULSE_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] signalStrength,
    input wire logic channelValid,
    input wire logic dataGroupEvent,
    output logic [18:0] tunedFreqKhz,
    output logic deemphasis50us,
    output logic gainControlOff,
    output logic [7:0] blendLowDbuv,
    output logic stereoIndication,
    output logic pinOneOut,
    output logic pinOneOe,
    output logic pinTwoOut,
    output logic pinTwoOe,
    output logic pinThreeOut,
    output logic pinThreeOe
);
    // =====================================================
    // bus slave
    logic ack_q;
    logic [31:0] rdata_q;
    logic busReq;
    logic wrStrobe;
    logic [5:0] regIdx;
    logic [15:0] chan_q;
    logic [15:0] cfg1_q;
    logic [15:0] bandCfg_q;
    logic [15:0] seekCtl_q;
    logic [15:0] statusWord;
    logic [15:0] readWord;
    logic wrChan;
    logic wrCfg1;
    logic wrBand;
    logic wrSeek;
    logic wrStatus;

    // byte enables cover the two low lanes; the top lanes hold nothing
    function automatic logic [15:0] mergeWrite(
        input logic [15:0] oldVal,
        input logic [15:0] newVal,
        input logic [1:0] sel,
        input logic [15:0] writable
    );
        logic [15:0] laneMask;
        laneMask = {{8{sel[1]}}, {8{sel[0]}}} & writable;
        return (oldVal & ~laneMask) | (newVal & laneMask);
    endfunction

    assign busReq = wb_cyc_i && wb_stb_i && !ack_q;
    assign wrStrobe = busReq && wb_we_i;
    assign regIdx = wb_adr_i[7:2];
    assign wrChan = wrStrobe && (regIdx == tuner_pkg::CHANNEL_IDX);
    assign wrCfg1 = wrStrobe && (regIdx == tuner_pkg::SYSCFG1_IDX);
    assign wrBand = wrStrobe && (regIdx == tuner_pkg::BAND_CFG_IDX);
    assign wrSeek = wrStrobe && (regIdx == tuner_pkg::SEEK_CTRL_IDX);
    assign wrStatus = wrStrobe && (regIdx == tuner_pkg::STATUS_IDX);

    // one wait state: ack follows the request by one edge, then drops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= busReq;
        end
    end

    always_comb begin
        case (regIdx)
            tuner_pkg::SEEK_CTRL_IDX: readWord = seekCtl_q;
            tuner_pkg::CHANNEL_IDX: readWord = chan_q;
            tuner_pkg::SYSCFG1_IDX: readWord = cfg1_q;
            tuner_pkg::BAND_CFG_IDX: readWord = bandCfg_q;
            tuner_pkg::STATUS_IDX: readWord = statusWord;
            default: readWord = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (busReq) begin
            rdata_q <= {16'h0000, readWord};
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // =====================================================
    // registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chan_q <= tuner_pkg::REG_RESET;
        end else if (wrChan) begin
            // only the host writes this field, so a seek leaves it alone
            chan_q <= mergeWrite(chan_q, wb_dat_i[15:0], wb_sel_i[1:0],
                tuner_pkg::CHANNEL_MASK); // RULE_06 RULE_22
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg1_q <= tuner_pkg::REG_RESET;
        end else if (wrCfg1) begin
            cfg1_q <= mergeWrite(cfg1_q, wb_dat_i[15:0], wb_sel_i[1:0],
                tuner_pkg::SYSCFG1_MASK);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bandCfg_q <= tuner_pkg::REG_RESET;
        end else if (wrBand) begin
            bandCfg_q <= mergeWrite(bandCfg_q, wb_dat_i[15:0], wb_sel_i[1:0],
                tuner_pkg::BAND_CFG_MASK);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            seekCtl_q <= tuner_pkg::REG_RESET;
        end else if (wrSeek) begin
            seekCtl_q <= mergeWrite(seekCtl_q, wb_dat_i[15:0], wb_sel_i[1:0],
                tuner_pkg::SEEK_CTRL_MASK);
        end
    end

    // =====================================================
    // band, spacing and frequency
    logic goBit;
    logic seekBit;
    logic [1:0] band;
    logic [1:0] spacingCode;
    logic [7:0] spacingKhz;
    logic [18:0] baseKhz;
    logic [18:0] topKhz;
    logic [9:0] readback_q;
    logic [9:0] stepChan;
    logic [18:0] stepFreq;
    logic stepOutOfBand;

    assign goBit = chan_q[tuner_pkg::GO_BIT];
    assign seekBit = seekCtl_q[tuner_pkg::SEEK_START_BIT];
    assign band = bandCfg_q[tuner_pkg::BAND_LSB +: 2];
    assign spacingCode = bandCfg_q[tuner_pkg::SPACING_LSB +: 2];

    always_comb begin
        case (spacingCode)
            2'h1: spacingKhz = tuner_pkg::SPACING_100_KHZ; // RULE_20
            2'h2: spacingKhz = tuner_pkg::SPACING_50_KHZ; // RULE_20
            default: spacingKhz = tuner_pkg::SPACING_200_KHZ; // RULE_20
        endcase
    end

    // reserved band code falls back to the default band
    always_comb begin
        case (band)
            2'h1: begin
                baseKhz = tuner_pkg::BASE_JAPAN_KHZ; // RULE_05
                topKhz = tuner_pkg::TOP_WIDE_KHZ; // RULE_19
            end
            2'h2: begin
                baseKhz = tuner_pkg::BASE_JAPAN_KHZ; // RULE_05
                topKhz = tuner_pkg::TOP_JAPAN_KHZ; // RULE_19
            end
            default: begin
                baseKhz = tuner_pkg::BASE_US_KHZ; // RULE_04
                topKhz = tuner_pkg::TOP_WIDE_KHZ; // RULE_19
            end
        endcase
    end

    // seek walks one channel at a time and stops at either band edge
    assign stepChan = seekCtl_q[tuner_pkg::SEEK_UP_BIT] ? readback_q + 10'h001
        : readback_q - 10'h001;
    assign stepFreq = 19'(stepChan) * 19'(spacingKhz) + baseKhz;
    assign stepOutOfBand = seekCtl_q[tuner_pkg::SEEK_UP_BIT]
        ? (stepFreq > topKhz) : (readback_q == 10'h000);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tunedFreqKhz <= tuner_pkg::BASE_US_KHZ;
        end else begin
            tunedFreqKhz <= 19'(readback_q) * 19'(spacingKhz) + baseKhz; // RULE_04 RULE_05
        end
    end

    // =====================================================
    // tune and seek engine
    tuner_pkg::engine_state_e state_q;
    logic [4:0] timer_q;
    logic timerDone;
    logic complete_q;
    logic fail_q;
    logic setComplete;
    logic setFail;
    logic clearTuneFlags;
    logic clearSeekFlags;

    assign timerDone = (timer_q == 5'h00);
    assign clearTuneFlags = wrChan && wb_sel_i[1] && !wb_dat_i[tuner_pkg::GO_BIT];
    assign clearSeekFlags = wrSeek && wb_sel_i[1] && !wb_dat_i[tuner_pkg::SEEK_START_BIT];
    assign setComplete = ((state_q == tuner_pkg::ENGINE_TUNING) && goBit && timerDone)
        || ((state_q == tuner_pkg::ENGINE_SEEKING) && seekBit && timerDone
        && (channelValid || stepOutOfBand));
    assign setFail = (state_q == tuner_pkg::ENGINE_SEEKING) && seekBit && timerDone
        && !channelValid && stepOutOfBand;

    // a set completion flag blocks a new start until the host writes either start bit to zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= tuner_pkg::ENGINE_IDLE;
        end else begin
            case (state_q)
                tuner_pkg::ENGINE_IDLE: begin
                    if (goBit && !complete_q) begin
                        state_q <= tuner_pkg::ENGINE_TUNING; // RULE_01 RULE_03
                    end else if (seekBit && !complete_q) begin
                        state_q <= tuner_pkg::ENGINE_SEEKING; // RULE_18
                    end
                end
                tuner_pkg::ENGINE_TUNING: begin
                    if (!goBit || timerDone) begin
                        state_q <= tuner_pkg::ENGINE_IDLE;
                    end
                end
                tuner_pkg::ENGINE_SEEKING: begin
                    if (!seekBit || setComplete) begin
                        state_q <= tuner_pkg::ENGINE_IDLE;
                    end
                end
                default: state_q <= tuner_pkg::ENGINE_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_q <= 5'h00;
        end else if (state_q == tuner_pkg::ENGINE_IDLE) begin
            timer_q <= 5'(tuner_pkg::TUNE_SETTLE_CYCLES - 1);
        end else if (timerDone) begin
            timer_q <= 5'(tuner_pkg::SEEK_STEP_CYCLES - 1);
        end else begin
            timer_q <= timer_q - 5'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readback_q <= 10'h000;
        end else if (state_q == tuner_pkg::ENGINE_IDLE && goBit && !complete_q) begin
            readback_q <= chan_q[tuner_pkg::CHAN_MSB:0]; // RULE_01
        end else if (state_q == tuner_pkg::ENGINE_SEEKING && seekBit && timerDone
                && !channelValid && !stepOutOfBand) begin
            readback_q <= stepChan; // RULE_07
        end
    end

    // set wins over a clear arriving in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            complete_q <= 1'b0;
        end else if (setComplete) begin
            complete_q <= 1'b1; // RULE_02 RULE_07
        end else if (clearTuneFlags || clearSeekFlags) begin
            complete_q <= 1'b0; // RULE_03 RULE_18
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fail_q <= 1'b0;
        end else if (setFail) begin
            fail_q <= 1'b1;
        end else if (clearSeekFlags) begin
            fail_q <= 1'b0; // RULE_18
        end
    end

    // =====================================================
    // data-group flag, stereo and analog controls
    logic dataReady_q;
    logic stereo_q;
    logic [1:0] blendCode;

    // cleared by writing one to its status bit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dataReady_q <= 1'b0;
        end else if (dataGroupEvent) begin
            dataReady_q <= 1'b1;
        end else if (wrStatus && wb_sel_i[1] && wb_dat_i[tuner_pkg::ST_DATA_READY_BIT]) begin
            dataReady_q <= 1'b0;
        end
    end

    assign blendCode = cfg1_q[tuner_pkg::BLEND_LSB +: 2];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            blendLowDbuv <= tuner_pkg::BLEND_LOW_0;
        end else begin
            case (blendCode)
                2'h1: blendLowDbuv <= tuner_pkg::BLEND_LOW_1; // RULE_16
                2'h2: blendLowDbuv <= tuner_pkg::BLEND_LOW_2; // RULE_16
                2'h3: blendLowDbuv <= tuner_pkg::BLEND_LOW_3; // RULE_16
                default: blendLowDbuv <= tuner_pkg::BLEND_LOW_0; // RULE_16
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stereo_q <= 1'b0;
        end else begin
            stereo_q <= (signalStrength > blendLowDbuv); // RULE_17
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            deemphasis50us <= 1'b0;
            gainControlOff <= 1'b0;
        end else begin
            deemphasis50us <= cfg1_q[tuner_pkg::DEEMPH_BIT]; // RULE_14
            gainControlOff <= cfg1_q[tuner_pkg::GAIN_OFF_BIT]; // RULE_15
        end
    end

    assign stereoIndication = stereo_q;
    assign statusWord = {dataReady_q, complete_q, fail_q, stereo_q,
        (state_q != tuner_pkg::ENGINE_IDLE), 1'b0, readback_q};

    // =====================================================
    // interrupt pulse on pin two
    irq_pulse_if irqPulse();
    logic complete_d1_q;
    logic dataReady_d1_q;
    logic [1:0] pin1Mode;
    logic [1:0] pin2Mode;
    logic [1:0] pin3Mode;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            complete_d1_q <= 1'b0;
            dataReady_d1_q <= 1'b0;
        end else begin
            complete_d1_q <= complete_q;
            dataReady_d1_q <= dataReady_q;
        end
    end

    assign pin1Mode = cfg1_q[tuner_pkg::PIN1_LSB +: 2];
    assign pin2Mode = cfg1_q[tuner_pkg::PIN2_LSB +: 2];
    assign pin3Mode = cfg1_q[tuner_pkg::PIN3_LSB +: 2];

    // fires on the flag's rising edge only, so a held flag pulses once
    assign irqPulse.trigger = (pin2Mode == tuner_pkg::PIN_SPECIAL)
        && ((complete_q && !complete_d1_q && cfg1_q[tuner_pkg::COMPLETE_IRQ_EN_BIT]) // RULE_08
        || (dataReady_q && !dataReady_d1_q
        && seekCtl_q[tuner_pkg::DATA_IRQ_EN_BIT])); // RULE_09

    irq_pulse_timer #(
        .pulseCycles(pulseCycles)
    ) pulseTimer (
        .clk(clk),
        .reset_n(reset_n),
        .pulse(irqPulse)
    );

    // =====================================================
    // pin drivers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinOneOut <= 1'b0;
            pinOneOe <= 1'b0;
        end else begin
            // reserved code 01 is left undriven
            pinOneOut <= (pin1Mode == tuner_pkg::PIN_HIGH); // RULE_13
            pinOneOe <= pin1Mode[1]; // RULE_13
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinTwoOut <= 1'b0;
            pinTwoOe <= 1'b0;
        end else begin
            case (pin2Mode)
                tuner_pkg::PIN_SPECIAL: pinTwoOut <= !irqPulse.active; // RULE_10
                tuner_pkg::PIN_HIGH: pinTwoOut <= 1'b1; // RULE_10
                default: pinTwoOut <= 1'b0; // RULE_10
            endcase
            pinTwoOe <= (pin2Mode != tuner_pkg::PIN_HIZ); // RULE_10
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinThreeOut <= 1'b0;
            pinThreeOe <= 1'b0;
        end else begin
            case (pin3Mode)
                tuner_pkg::PIN_SPECIAL: pinThreeOut <= stereo_q; // RULE_11 RULE_12
                tuner_pkg::PIN_HIGH: pinThreeOut <= 1'b1; // RULE_11
                default: pinThreeOut <= 1'b0; // RULE_11
            endcase
            pinThreeOe <= (pin3Mode != tuner_pkg::PIN_HIZ); // RULE_11
        end
    end

endmodule // tuner_channel_and_pin_config
`default_nettype wire

// file: hdl/tuner_pkg.sv
// constants shared by the tuner control block and its pulse timer
// assumes a 25 MHz system clock and a 32-bit classic wishbone master
package tuner_pkg;

    localparam int unsigned CLK_MHZ = 25;
    // =====================================================
    // register indexes; byte address is four times the index
    localparam logic [5:0] SEEK_CTRL_IDX = 6'h02;
    localparam logic [5:0] CHANNEL_IDX = 6'h03;
    localparam logic [5:0] SYSCFG1_IDX = 6'h04;
    localparam logic [5:0] BAND_CFG_IDX = 6'h05;
    localparam logic [5:0] STATUS_IDX = 6'h0A;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // =====================================================
    // writable bits of each register, reserved bits stay zero
    localparam logic [15:0] SEEK_CTRL_MASK = 16'h8300;
    localparam logic [15:0] CHANNEL_MASK = 16'h83FF;
    localparam logic [15:0] SYSCFG1_MASK = 16'h4CFF;
    localparam logic [15:0] BAND_CFG_MASK = 16'h00F0;
    // =====================================================
    // field positions
    localparam int GO_BIT = 15;
    localparam int CHAN_MSB = 9;
    localparam int DATA_IRQ_EN_BIT = 15;
    localparam int SEEK_UP_BIT = 9;
    localparam int SEEK_START_BIT = 8;
    localparam int COMPLETE_IRQ_EN_BIT = 14;
    localparam int DEEMPH_BIT = 11;
    localparam int GAIN_OFF_BIT = 10;
    localparam int BLEND_LSB = 6;
    localparam int PIN3_LSB = 4;
    localparam int PIN2_LSB = 2;
    localparam int PIN1_LSB = 0;
    localparam int BAND_LSB = 6;
    localparam int SPACING_LSB = 4;
    localparam int ST_DATA_READY_BIT = 15;
    localparam int ST_COMPLETE_BIT = 14;
    localparam int ST_FAIL_BIT = 13;
    localparam int ST_STEREO_BIT = 12;
    localparam int ST_BUSY_BIT = 11;
    // =====================================================
    // pin modes
    localparam logic [1:0] PIN_HIZ = 2'h0;
    localparam logic [1:0] PIN_SPECIAL = 2'h1;
    localparam logic [1:0] PIN_LOW = 2'h2;
    localparam logic [1:0] PIN_HIGH = 2'h3;
    // =====================================================
    // frequencies in kHz
    localparam logic [18:0] BASE_US_KHZ = 19'd87500;
    localparam logic [18:0] BASE_JAPAN_KHZ = 19'd76000;
    localparam logic [18:0] TOP_WIDE_KHZ = 19'd108000;
    localparam logic [18:0] TOP_JAPAN_KHZ = 19'd90000;
    localparam logic [7:0] SPACING_200_KHZ = 8'd200;
    localparam logic [7:0] SPACING_100_KHZ = 8'd100;
    localparam logic [7:0] SPACING_50_KHZ = 8'd50;
    // =====================================================
    // blend window lower ends in dBuV
    localparam logic [7:0] BLEND_LOW_0 = 8'd31;
    localparam logic [7:0] BLEND_LOW_1 = 8'd37;
    localparam logic [7:0] BLEND_LOW_2 = 8'd19;
    localparam logic [7:0] BLEND_LOW_3 = 8'd25;
    // =====================================================
    // timing
    localparam int unsigned PULSE_TIME_US = 5000;
    localparam int unsigned PULSE_CYCLES = PULSE_TIME_US * CLK_MHZ;
    localparam int unsigned TUNE_SETTLE_CYCLES = 16;
    localparam int unsigned SEEK_STEP_CYCLES = 16;

    typedef enum logic [1:0] {
        ENGINE_IDLE = 2'b00,
        ENGINE_TUNING = 2'b01,
        ENGINE_SEEKING = 2'b10
    } engine_state_e;

endpackage

// file: hdl/irq_pulse_if.sv
// carrier between the control block and its interrupt pulse timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface irq_pulse_if;
    logic trigger;
    logic active;
    modport requester (output trigger, input active);
    modport timer (input trigger, output active);
endinterface
`default_nettype wire

// file: hdl/irq_pulse_timer.sv
// fixed-length pulse timer for the interrupt pin
// assumes trigger is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module irq_pulse_timer #(
    parameter int unsigned pulseCycles = tuner_pkg::PULSE_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    irq_pulse_if.timer pulse
);
    logic [23:0] count_q;

    // a new event during a pulse restarts the full width
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 24'h00_0000;
        end else if (pulse.trigger) begin
            count_q <= 24'(pulseCycles); // RULE_21
        end else if (count_q != 24'h00_0000) begin
            count_q <= count_q - 24'h00_0001; // RULE_21
        end
    end

    assign pulse.active = (count_q != 24'h00_0000);
endmodule // irq_pulse_timer
`default_nettype wire

// file: bench/tuner_props.sv
// port checker of the tuner control block
// assumes outputs follow a register write one edge late
`timescale 1ns/1ps
`default_nettype none
module tuner_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] signalStrength,
    input wire logic [7:0] blendLowDbuv,
    input wire logic stereoIndication,
    input wire logic deemphasis50us,
    input wire logic gainControlOff,
    input wire logic pinOneOut,
    input wire logic pinOneOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence cfgWr(b); req ##0 (wb_we_i && wb_adr_i == 8'h10 && wb_sel_i[b]); endsequence
    ack_follows_a: assert property (req |=> wb_ack_o) else $error("no ack");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    upper_zero_a:
        assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper set");
    unmapped_zero_a:
        assert property (req ##0 (!wb_we_i && wb_adr_i == 8'h00) |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped data");
    stereo_cmp_a:
        assert property ($past(reset_n) |-> stereoIndication ==
            ($past(signalStrength) > $past(blendLowDbuv))) else $error("stereo wrong");
    cfg_bits_a:
        assert property (cfgWr(1) |-> ##2 {deemphasis50us, gainControlOff} ==
            $past(wb_dat_i[11:10], 2)) else $error("cfg bits");
    blend_table_a:
        assert property (cfgWr(0) |-> ##2 blendLowDbuv ==
            8'(32'h1913_251F >> {$past(wb_dat_i[7:6], 2), 3'h0})) else $error("blend");
    pin_one_mode_a:
        assert property (cfgWr(0) |-> ##2 {pinOneOe, pinOneOut} ==
            {$past(wb_dat_i[1], 2), &$past(wb_dat_i[1:0], 2)}) else $error("pin one");
endmodule // tuner_props
bind tuner_channel_and_pin_config tuner_props tuner_props_inst (.*);
`default_nettype wire

// file: bench/wb_host.sv
// host model: classic single wishbone cycles
// assumes a one-cycle ack from the block
`timescale 1ns/1ps
`default_nettype none
module wb_host (
    input wire logic clk,
    input wire logic ack,
    output logic cyc = 1'b0,
    output logic we = 1'b0,
    output logic [7:0] adr = 8'h00,
    output logic [31:0] dat = 32'h0000_0000
);
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {16'h0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        // released data turns over so stale bits never pass as valid
        dat <= ~dat;
    endtask
endmodule // wb_host
`default_nettype wire

// file: bench/tuner_channel_and_pin_config_test.sv
// bench of the tuner block; reads are checked from a queue
// assumes the checker is bound to the block
`timescale 1ns/1ps
`default_nettype none
module tuner_channel_and_pin_config_test;
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
    logic clk = 1'b0, resetN = 1'b0, grpEvt = 1'b0, cv = 1'b0, cyc, we, ack, stereo, de, agc;
    logic p1o, p1e, p2o, p2e, p3o, p3e;
    logic [7:0] adr, blend, strength = 8'h00;
    logic [31:0] wdat, rdat, expRd, rng = 32'h0000_004C;
    logic [18:0] freq;
    logic [15:0] expQ[$];
    int err_total = 0, cmp_count = 0, ticks = 0, lows;
    always #20 clk = ~clk;
    tuner_channel_and_pin_config #(.pulseCycles(20)) tuner_channel_and_pin_config_inst (
        .clk(clk), .reset_n(resetN), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .signalStrength(strength), .channelValid(cv), .dataGroupEvent(grpEvt),
        .tunedFreqKhz(freq), .deemphasis50us(de), .gainControlOff(agc), .blendLowDbuv(blend),
        .stereoIndication(stereo), .pinOneOut(p1o), .pinOneOe(p1e), .pinTwoOut(p2o),
        .pinTwoOe(p2e), .pinThreeOut(p3o), .pinThreeOe(p3e));
    wb_host wb_host_inst (.clk(clk), .ack(ack), .cyc(cyc), .we(we), .adr(adr), .dat(wdat));
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        expQ.push_back(e);
        wb_host_inst.xfer(1'b0, a, 16'h0000);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wb_host_inst.xfer(1'b1, a, d);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse_len();
        lows = 0;
        for (int i = 0; i < 60 && p2o !== 1'b0; i++) @(posedge clk);
        while (p2o === 1'b0 && lows < 99) begin
            @(posedge clk);
            lows++;
        end
        `CHK("pulse", 20, lows)
    endtask
    task automatic end_of_test();
        if (ticks > 5000) err_total++;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        if (++ticks > 5000) end_of_test();
        if (ack === 1'b1 && we === 1'b0) begin
            expRd = {16'h0000, expQ.pop_front()};
            `CHK("read", expRd, rdat)
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        resetN <= 1'b1;
        rd(8'h00, 16'h0000);
        rd(8'h10, 16'h0000);
        wr(8'h10, 16'h4004);
        wr(8'h0C, 16'h8005);
        pulse_len();
        `CHK("freq", 19'd88500, freq)
        rd(8'h28, 16'h4005);
        wr(8'h14, 16'h0050);
        wt(2);
        `CHK("freq", 19'd76500, freq)
        wr(8'h0C, 16'h0002);
        rd(8'h28, 16'h0005);
        wr(8'h08, 16'h0100);
        wt(150);
        rd(8'h28, 16'h6000);
        rd(8'h0C, 16'h0002);
        wr(8'h08, 16'h8000);
        rd(8'h28, 16'h0000);
        cv <= 1'b1;
        wr(8'h08, 16'h8300);
        wt(45);
        rd(8'h28, 16'h4000);
        wr(8'h10, 16'h0004);
        grpEvt <= 1'b1;
        @(posedge clk);
        grpEvt <= 1'b0;
        pulse_len();
        for (int m = 0; m < 4; m++) begin
            logic [7:0] lo;
            lo = 8'(32'h1913_251F >> (8 * m));
            rng ^= rng << 13;
            rng ^= rng >> 17;
            rng ^= rng << 5;
            strength <= rng[7:0];
            wr(8'h10, {4'h0, 2'(m), 2'h0, {4{2'(m)}}});
            rd(8'h10, {4'h0, 2'(m), 2'h0, {4{2'(m)}}});
            wt(3);
            `CHK("pin1", {m[1], m == 3}, {p1e, p1o})
            `CHK("pin2", {m != 0, m[0]}, {p2e, p2o})
            `CHK("pin3", {m != 0, m == 3 || (m == 1 && strength > lo)}, {p3e, p3o})
            `CHK("stereo", strength > lo, stereo)
            `CHK("cfg", 2'(m), {de, agc})
        end
        end_of_test();
    end
endmodule // tuner_channel_and_pin_config_test
`default_nettype wire
